// *** csx_regs.vh ***
// constants for the subtract, swap, table and xor execution slice
`ifndef CSX_REGS_VH
`define CSX_REGS_VH
`define CSX_OP_SUBLIT   6'h02
`define CSX_OP_XORLIT   6'h02
`define CSX_OP_SUBF     6'h17
`define CSX_OP_SUBFB    6'h16
`define CSX_OP_SWAP     6'h0e
`define CSX_OP_XORF     6'h06
`define CSX_OP_TST      7'h33
`define CSX_OP_TBL      13'h0001
`define CSX_TBLWR_BIT   2
`define CSX_IDX_MAX     8'h5f
`define CSX_ST_N        4
`define CSX_ST_OV       3
`define CSX_ST_Z        2
`define CSX_ST_DC       1
`define CSX_ST_C        0
`define CSX_PTR_W       21
`define CSX_PTR_RST     21'h000000
`define CSX_TBL_NONE    2'h0
`define CSX_TBL_POSTINC 2'h1
`define CSX_TBL_POSTDEC 2'h2
`define CSX_TBL_PREINC  2'h3
`define CSX_HOLD_DEPTH  8
`define CSX_HOLD_AW     3
`endif

// *** csx_hold_mem.v ***
// eight-entry table write holding register bank
`timescale 1ns/10ps
module csx_hold_mem #(
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire          clk,
    input  wire          rstn,
    // write side
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [7:0]    wr_data,
    // registered read side
    input  wire [AW-1:0] rd_addr,
    output reg  [7:0]    rd_data
);
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    // storage cleared to erased value so the flash side sees ff
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= 8'hff;
            end
            rd_data <= 8'hff;
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// *** csx_exec.v ***
// execution slice: subtract, swap, table read/write, test-skip, xor
`timescale 1ns/10ps
`include "csx_regs.vh"
module csx_exec #(
    parameter PTR_W = `CSX_PTR_W
) (
    // clock and reset
    input  wire             clk,
    input  wire             rstn,
    // instruction issue, one instruction per accepted cycle
    input  wire             instr_valid,
    input  wire [15:0]      instr,
    input  wire             next_two_word,
    input  wire             extended_set_enable,
    // data register file read port
    input  wire [7:0]       file_rdata,
    input  wire [7:0]       fsr2_base,
    // program memory word read
    input  wire [15:0]      prog_rdata,
    // data register file write port
    output reg  [11:0]      file_addr,
    output reg              file_we,
    output reg  [11:0]      file_waddr,
    output reg  [7:0]       file_wdata,
    // program memory address
    output reg  [PTR_W-1:0] prog_addr,
    // architectural state
    output reg  [7:0]       working_reg_file,
    output reg  [3:0]       bank_select_register,
    output reg  [4:0]       status,
    output reg  [PTR_W-1:0] table_pointer,
    output reg  [7:0]       table_latch,
    // issue control
    output reg              busy,
    output reg              flush,
    // holding register observation
    output reg  [7:0]       hold_rdata,
    output reg              hold_we
);
    // cycle sequencer states
    localparam ST_EXEC  = 2'b00;
    localparam ST_TABLE_READ_OP = 2'b01;
    localparam ST_TABLE_WRITE_OP = 2'b10;
    localparam ST_SKIP  = 2'b11;

    reg  [1:0]  state;
    reg  [1:0]  tbl_mode;
    reg         skip_extra;
    reg  [1:0]  next_state;
    reg  [7:0]  res;
    reg         wr_dest;
    reg         wr_w;
    reg  [4:0]  next_status;
    reg  [PTR_W-1:0] next_ptr;
    reg         start_tbl;
    reg         start_skip;
    wire [7:0]  hold_q;

    // decoded opcode fields
    wire [5:0]  op6     = instr[15:10];
    wire        dbit    = instr[9];
    wire        abit    = instr[8];
    wire [7:0]  ffield  = instr[7:0];
    wire [7:0]  lit     = instr[7:0];
    // read and write share the top bits; bit 2 tells them apart
    wire        is_tbl  = (instr[15:3] == `CSX_OP_TBL);
    wire        tbl_wr  = instr[`CSX_TBLWR_BIT];
    wire        c_in    = status[`CSX_ST_C];

    // pointer step used for post update modes
    function [PTR_W-1:0] ptr_step;
        input [PTR_W-1:0] p;
        input [1:0]       mode;
        begin
            case (mode)
                `CSX_TBL_POSTINC: ptr_step = p + 1'b1;
                `CSX_TBL_POSTDEC: ptr_step = p - 1'b1;
                `CSX_TBL_PREINC:  ptr_step = p + 1'b1;
                default:          ptr_step = p;
            endcase
        end
    endfunction

    // a - b - borrow with n, ov, z, dc, c flags (carry means no borrow)
    function [12:0] sub_flags;
        input [7:0] a;
        input [7:0] b;
        input       bin;
        reg   [8:0] s;
        reg   [4:0] lo;
        begin
            s  = {1'b0, a} - {1'b0, b} - {8'h00, bin};
            lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
            sub_flags[12:5] = s[7:0];
            sub_flags[`CSX_ST_N]  = s[7];
            sub_flags[`CSX_ST_OV] = (a[7] ^ b[7]) & (a[7] ^ s[7]);
            sub_flags[`CSX_ST_Z]  = (s[7:0] == 8'h00);
            sub_flags[`CSX_ST_DC] = ~lo[4];
            sub_flags[`CSX_ST_C]  = ~s[8];
        end
    endfunction

    // data address forming: access bank, banked or indexed offset
    always @* begin
        if (abit) begin
            file_addr = {bank_select_register, ffield};
        end else if (extended_set_enable && ffield <= `CSX_IDX_MAX) begin
            file_addr = {4'h0, fsr2_base + ffield};
        end else if (ffield[7]) begin
            file_addr = {4'hf, ffield};
        end else begin
            file_addr = {4'h0, ffield};
        end
    end

    // single-cycle datapath and sequencer decisions
    always @* begin
        res         = 8'h00;
        wr_dest     = 1'b0;
        wr_w        = 1'b0;
        next_status = status;
        next_state  = state;
        start_tbl   = 1'b0;
        start_skip  = 1'b0;
        if (state == ST_EXEC && instr_valid) begin
            if (op6 == `CSX_OP_SUBLIT && instr[9:8] == 2'b00) begin
                {res, next_status} = sub_flags(lit, working_reg_file,
                                               1'b0);
                wr_w = 1'b1;
            end else if (op6 == `CSX_OP_XORLIT && instr[9:8] == 2'b10) begin
                res = working_reg_file ^ lit;
                next_status[`CSX_ST_N] = res[7];
                next_status[`CSX_ST_Z] = (res == 8'h00);
                wr_w = 1'b1;
            end else if (op6 == `CSX_OP_SUBF) begin
                {res, next_status} = sub_flags(file_rdata, working_reg_file,
                                               1'b0);
                wr_dest = 1'b1;
            end else if (op6 == `CSX_OP_SUBFB) begin
                {res, next_status} = sub_flags(file_rdata, working_reg_file,
                                               ~c_in);
                wr_dest = 1'b1;
            end else if (op6 == `CSX_OP_SWAP) begin
                res = {file_rdata[3:0], file_rdata[7:4]};
                wr_dest = 1'b1;
            end else if (op6 == `CSX_OP_XORF) begin
                res = working_reg_file ^ file_rdata;
                next_status[`CSX_ST_N] = res[7];
                next_status[`CSX_ST_Z] = (res == 8'h00);
                wr_dest = 1'b1;
            end else if (instr[15:9] == `CSX_OP_TST) begin
                if (file_rdata == 8'h00) begin
                    start_skip = 1'b1;
                    next_state = ST_SKIP;
                end
            end else if (is_tbl) begin
                start_tbl  = 1'b1;
                next_state = tbl_wr ? ST_TABLE_WRITE_OP : ST_TABLE_READ_OP;
            end
            if (wr_dest) begin
                wr_w = ~dbit;
            end
        end else if (state == ST_SKIP) begin
            next_state = skip_extra ? ST_SKIP : ST_EXEC;
        end else if (state != ST_EXEC) begin
            next_state = ST_EXEC;
        end
    end

    // pointer for the access: pre-increment applied before use
    always @* begin
        if (start_tbl && instr[1:0] == `CSX_TBL_PREINC) begin
            next_ptr = table_pointer + 1'b1;
        end else begin
            next_ptr = table_pointer;
        end
    end

    // holding registers: latch read and written in the second cycle
    csx_hold_mem #(
        .DEPTH (`CSX_HOLD_DEPTH),
        .AW    (`CSX_HOLD_AW)
    ) u_hold (
        .clk     (clk),
        .rstn    (rstn),
        .wr_en   (state == ST_TABLE_WRITE_OP),
        .wr_addr (table_pointer[`CSX_HOLD_AW-1:0]),
        .wr_data (table_latch),
        .rd_addr (table_pointer[`CSX_HOLD_AW-1:0]),
        .rd_data (hold_q)
    );

    // architectural registers and sequencer
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state                <= ST_EXEC;
            tbl_mode             <= `CSX_TBL_NONE;
            skip_extra           <= 1'b0;
            working_reg_file     <= 8'h00;
            bank_select_register <= 4'h0;
            status               <= 5'h00;
            table_pointer        <= `CSX_PTR_RST;
            table_latch          <= 8'h00;
            file_we              <= 1'b0;
            file_waddr           <= 12'h000;
            file_wdata           <= 8'h00;
            prog_addr            <= `CSX_PTR_RST;
            busy                 <= 1'b0;
            flush                <= 1'b0;
            hold_rdata           <= 8'hff;
            hold_we              <= 1'b0;
        end else begin
            state      <= next_state;
            status     <= next_status;
            file_we    <= wr_dest & ~wr_w;
            file_waddr <= file_addr;
            file_wdata <= res;
            hold_we    <= (state == ST_TABLE_WRITE_OP);
            hold_rdata <= hold_q;
            busy       <= (next_state != ST_EXEC);
            flush      <= start_skip;
            if (wr_w) begin
                working_reg_file <= res;
            end
            if (start_tbl) begin
                tbl_mode      <= instr[1:0];
                table_pointer <= next_ptr;
                prog_addr     <= next_ptr;
            end
            if (start_skip) begin
                skip_extra <= next_two_word;
            end else if (state == ST_SKIP) begin
                skip_extra <= 1'b0;
            end
            // second cycle: pick byte, then post update pointer
            if (state == ST_TABLE_READ_OP) begin
                if (table_pointer[0]) begin
                    table_latch <= prog_rdata[15:8];
                end else begin
                    table_latch <= prog_rdata[7:0];
                end
            end
            if ((state == ST_TABLE_READ_OP || state == ST_TABLE_WRITE_OP) &&
                tbl_mode != `CSX_TBL_PREINC) begin
                table_pointer <= ptr_step(table_pointer, tbl_mode);
            end
        end
    end
endmodule

// *** csx_mem_model.sv ***
// data register file and program memory model
`timescale 1ns/10ps
module csx_mem_model (
    // data register file
    input  wire        clk,
    input  wire [11:0] file_addr,
    input  wire        file_we,
    input  wire [11:0] file_waddr,
    input  wire [7:0]  file_wdata,
    output wire [7:0]  file_rdata,
    // program memory
    input  wire [20:0] prog_addr,
    output wire [15:0] prog_rdata
);
    reg [7:0] ram [0:4095];
    // reads settle within the cycle; words differ per byte lane
    assign file_rdata = ram[file_addr];
    assign prog_rdata = {prog_addr[8:1] ^ 8'h3c, prog_addr[8:1] ^ 8'h5a};
    // write port lands on the edge after the core raises it
    always @(posedge clk) begin
        if (file_we)
            ram[file_waddr] <= file_wdata;
    end
endmodule

// *** csx_exec_sva.sv ***
// port assertions for the execution slice
`timescale 1ns/10ps
module csx_exec_sva #(
    parameter PTR_W = 21
) (
    // clock, reset and issue
    input wire             clk,
    input wire             rstn,
    input wire             instr_valid,
    input wire [15:0]      instr,
    input wire             next_two_word,
    input wire [7:0]       file_rdata,
    // results
    input wire [7:0]       working_reg_file,
    input wire [4:0]       status,
    input wire [PTR_W-1:0] table_pointer,
    input wire             busy,
    input wire             hold_we
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // accepted instruction classes
    wire tk  = instr_valid && !busy;
    wire tbl = tk && instr[15:3] == 13'h0001;
    wire zr  = tk && instr[15:9] == 7'h33 && file_rdata == 8'h00;
    chk_sub_lit: assert property (tk && instr[15:8] == 8'h08 |=>
        working_reg_file == $past(instr[7:0]) - $past(working_reg_file)
        && status[0] == ($past(instr[7:0]) >= $past(working_reg_file)))
        else $error("literal subtract wrong");
    chk_xor_lit: assert property (tk && instr[15:8] == 8'h0a |=>
        working_reg_file == ($past(working_reg_file) ^ $past(instr[7:0]))
        && status[3] == $past(status[3]) && status[1:0] == $past(status[1:0]))
        else $error("literal xor wrong");
    chk_flags_kept: assert property (tbl || zr ||
        tk && instr[15:10] == 6'h0e |=> $stable(status))
        else $error("status changed");
    chk_tbl_cycles: assert property (tbl |=> busy ##1 !busy)
        else $error("table op length wrong");
    chk_ptr_inc: assert property (tbl && instr[0] |=> ##1
        table_pointer == $past(table_pointer, 2) + 1'b1)
        else $error("pointer not incremented");
    chk_hold_we: assert property (tbl && instr[2] |-> ##[1:3] hold_we)
        else $error("holding write missing");
    chk_skip_one: assert property (zr && !next_two_word |=>
        busy ##1 !busy) else $error("skip length wrong");
    chk_skip_two: assert property (zr && next_two_word |=>
        busy[*2] ##1 !busy) else $error("long skip length wrong");
endmodule
bind csx_exec csx_exec_sva #(.PTR_W(PTR_W)) u_sva (.clk, .rstn, .instr_valid,
    .instr, .next_two_word, .file_rdata, .working_reg_file, .status,
    .table_pointer, .busy, .hold_we);

// *** csx_exec_tb_top.sv ***
// self-checking bench for the execution slice
`timescale 1ns/10ps
module csx_exec_tb_top;
    // stimulus and observation
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg         instr_valid = 1'b0;
    reg  [15:0] instr = 16'h0000;
    reg         next_two_word = 1'b0;
    reg         extended_set_enable = 1'b0;
    reg  [7:0]  fsr2_base = 8'h40;
    wire [7:0]  file_rdata, file_wdata, working_reg_file, table_latch, hold_rdata;
    wire [15:0] prog_rdata;
    wire [11:0] file_addr, file_waddr;
    wire [20:0] prog_addr, table_pointer;
    wire [4:0]  status;
    wire        file_we, busy, flush, hold_we;
    integer     n_errors = 0, check_count = 0, n_busy = 0, n_flush = 0;
    // clock and flush pulse counter
    always #25 clk = ~clk;
    always @(posedge clk) if (flush === 1'b1) n_flush = n_flush + 1;
    csx_exec dut (.clk, .rstn, .instr_valid, .instr, .next_two_word,
        .extended_set_enable, .file_rdata, .fsr2_base, .prog_rdata, .file_addr,
        .file_we, .file_waddr, .file_wdata, .prog_addr, .working_reg_file,
        .bank_select_register(), .status, .table_pointer, .table_latch, .busy,
        .flush, .hold_rdata, .hold_we);
    csx_mem_model mem (.clk, .file_addr, .file_we, .file_waddr, .file_wdata,
        .file_rdata, .prog_addr, .prog_rdata);
    task check(input logic [47:0] seen, input logic [47:0] exp, input [39:0] nm);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // issue one instruction, then count busy cycles under a bound
    task op(input [15:0] code);
        integer i;
        begin
            @(posedge clk);
            instr <= code;
            instr_valid <= 1'b1;
            @(posedge clk);
            instr_valid <= 1'b0;
            #1 n_busy = 0;
            for (i = 0; i < 6 && busy === 1'b1; i = i + 1) begin
                n_busy = n_busy + 1;
                @(posedge clk);
                #1;
            end
        end
    endtask
    task setw(input [7:0] v);
        begin
            op({8'h0a, working_reg_file ^ v});
            check(working_reg_file, v, "w");
            check({status[4], status[2]}, {v[7], v == 8'h00}, "nz");
        end
    endtask
    task sl(input [7:0] w, input [7:0] k, input [7:0] r, input [4:0] s);
        begin
            setw(w);
            op({8'h08, k});
            check(working_reg_file, r, "w");
            check(status, s, "stat");
        end
    endtask
    // file ops on 0x20; setw keeps carry so borrow chains through
    task sf(input [5:0] oc, input d, input [7:0] fv, input [7:0] w,
            input [7:0] r, input [4:0] s);
        begin
            mem.ram[12'h020] = fv;
            setw(w);
            op({oc, d, 1'b0, 8'h20});
            @(posedge clk);
            #1;
            check(d ? mem.ram[12'h020] : working_reg_file, r, "dst");
            check(d ? working_reg_file : mem.ram[12'h020], d ? w : fv, "oth");
            check(status, s, "stat");
        end
    endtask
    task sw(input a, input [7:0] f, input [11:0] ad, input [7:0] v);
        begin
            mem.ram[ad] = v;
            op({6'h0e, 1'b0, a, f});
            check(working_reg_file, {v[3:0], v[7:4]}, "swap");
        end
    endtask
    task tr(input [1:0] nn, input [20:0] p, input [7:0] l);
        begin
            op({14'h0002, nn});
            check(table_pointer, p, "ptr");
            check(table_latch, l, "lat");
        end
    endtask
    task tw(input [15:0] code, input [20:0] p, input [7:0] h);
        begin
            op(code);
            check(n_busy, 1, "cyc");
            repeat (2) @(posedge clk);
            #1;
            check(table_pointer, p, "ptr");
            check(hold_rdata, h, "hold");
        end
    endtask
    task ts(input [7:0] v, input two, input [31:0] nb, input [31:0] nf);
        begin
            mem.ram[12'h020] = v;
            @(posedge clk);
            next_two_word <= two;
            n_flush = 0;
            op({7'h33, 1'b0, 8'h20});
            @(posedge clk);
            #1;
            check(n_busy, nb, "cyc");
            check(n_flush, nf, "flush");
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1 check({working_reg_file, status, table_latch, table_pointer}, 0, "rst");
        check(hold_rdata, 8'hff, "rst");
        sl(8'h01, 8'h02, 8'h01, 5'h03);
        sl(8'h02, 8'h02, 8'h00, 5'h07);
        sl(8'h03, 8'h02, 8'hff, 5'h10);
        sl(8'h01, 8'h80, 8'h7f, 5'h09);
        $display("sub literal done");
        sf(6'h17, 1'b1, 8'h03, 8'h02, 8'h01, 5'h03);
        sf(6'h17, 1'b0, 8'h02, 8'h02, 8'h00, 5'h07);
        sf(6'h16, 1'b1, 8'h19, 8'h0d, 8'h0c, 5'h01);
        sf(6'h16, 1'b1, 8'h03, 8'h0e, 8'hf5, 5'h10);
        sf(6'h16, 1'b0, 8'h1b, 8'h1a, 8'h00, 5'h07);
        sf(6'h06, 1'b1, 8'haf, 8'hb5, 8'h1a, 5'h03);
        sf(6'h06, 1'b0, 8'h1a, 8'h1a, 8'h00, 5'h07);
        $display("file ops done");
        sw(1'b1, 8'h90, 12'h090, 8'h53);
        sw(1'b0, 8'h90, 12'hf90, 8'ha7);
        extended_set_enable <= 1'b1;
        sw(1'b0, 8'h10, 12'h050, 8'h12);
        sw(1'b0, 8'h60, 12'h060, 8'h34);
        sw(1'b1, 8'h10, 12'h010, 8'h56);
        extended_set_enable <= 1'b0;
        $display("addressing done");
        tr(2'h2, 21'h1fffff, 8'h5a);
        tr(2'h0, 21'h1fffff, 8'hc3);
        tr(2'h3, 21'h000000, 8'h5a);
        tr(2'h1, 21'h000001, 8'h5a);
        tr(2'h0, 21'h000001, 8'h3c);
        tr(2'h3, 21'h000002, 8'h5b);
        tw(16'h000c, 21'h000002, 8'h5b);
        tw(16'h000f, 21'h000003, 8'h5b);
        tw(16'h000b, 21'h000004, 8'hff);
        tw(16'h000e, 21'h000003, 8'h5b);
        tw(16'h000d, 21'h000004, 8'h58);
        $display("table done");
        ts(8'h00, 1'b0, 1, 1);
        ts(8'h00, 1'b1, 2, 1);
        ts(8'h01, 1'b0, 0, 0);
        $display("skip done");
        finish_test;
    end
    // hang guard, over fifty times the expected run
    initial begin
        #400000;
        n_errors = n_errors + 1;
        finish_test;
    end
    task finish_test;
        begin
            $display("checks %0d errors %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
endmodule
